// *** rtl/cfgsg_pkg.sv ***
package cfgsg_pkg;

    // key geometry: one 256-bit user key, loaded as eight 32-bit words
    localparam int KEY_BITS  = 256;
    localparam int KEY_WORDS = 8;
    localparam int WORD_BITS = 32;

    // apb map
    localparam int          ADDR_W   = 12;
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STAT_OFS = 12'h004;

    // control register fields
    localparam int   CTRL_TAMPER_BIT = 0;
    localparam int   CTRL_KEYSEL_BIT = 1;
    localparam logic KEYSEL_RESET    = 1'b0;

    // status register fields
    localparam int ST_SECURE_BIT = 0;
    localparam int ST_TAMPER_BIT = 1;
    localparam int ST_VKEY_BIT   = 2;
    localparam int ST_NVKEY_BIT  = 3;
    localparam int ST_ACC_BIT    = 4;
    localparam int ST_REJ_BIT    = 5;
    localparam int ST_USER_BIT   = 6;
    localparam int ST_KEYSEL_BIT = 7;

    // configuration-clock to data-word ratio reported to the source
    localparam logic [2:0] RATIO_PLAIN = 3'h1;
    localparam logic [2:0] RATIO_FAST  = 3'h4;

    // configuration schemes
    typedef enum logic [1:0] {
        SCH_JTAG          = 2'h0,
        SCH_PASSIVE       = 2'h1,
        SCH_ACTIVE        = 2'h2,
        SCH_FAST_PARALLEL = 2'h3
    } cfgsg_scheme_t;

    // decoded instruction codes handed over by the tap controller
    typedef enum logic [3:0] {
        INS_SAMPLE        = 4'h0,
        INS_EXTEST        = 4'h1,
        INS_IDCODE        = 4'h2,
        INS_ERR_DETECT    = 4'h3,
        INS_USERCODE      = 4'h4,
        INS_HIGHZ         = 4'h5,
        INS_CLAMP         = 4'h6,
        INS_RECONFIG      = 4'h7,
        INS_CONFIG_IO     = 4'h8,
        INS_LOCK          = 4'h9,
        INS_UNLOCK        = 4'hA,
        INS_CLEAR_VOL_KEY = 4'hB,
        INS_KEY_CHECK     = 4'hC,
        INS_BYPASS        = 4'hF
    } cfgsg_instr_t;

endpackage

// *** rtl/cfgsg_ir_filter.sv ***
`timescale 1ns/1ps
`default_nettype none

// issues each loaded instruction, replaced by bypass when not permitted
module cfgsg_ir_filter
    import cfgsg_pkg::*;
(
    input  wire logic       clk_sys,    // system clock
    input  wire logic       resetn,     // sync reset, active low
    input  wire logic [3:0] ir_code,    // instruction from tap
    input  wire logic       ir_update,  // instruction loaded, pulse
    input  wire logic       secure,     // secure state active
    output logic      [3:0] exec_code,  // instruction to execute
    output logic            exec_pulse  // execute strobe
);

    // the small set still usable while secure, plus lock and unlock
    function automatic logic allowed_in_secure(input logic [3:0] c);
        return (c == INS_SAMPLE) || (c == INS_BYPASS) ||
               (c == INS_EXTEST) || (c == INS_IDCODE) ||
               (c == INS_ERR_DETECT) || (c == INS_LOCK) ||
               (c == INS_UNLOCK);
    endfunction

    wire blocked = secure && !allowed_in_secure(ir_code);

    // blocked codes become bypass so nothing else changes
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            exec_code  <= INS_BYPASS;
            exec_pulse <= 1'b0;
        end
        else
        begin
            exec_pulse <= ir_update;
            if (ir_update)
                exec_code <= blocked ? INS_BYPASS : ir_code;
        end
    end

    AST_SECURE_FILTER: assert property (@(posedge clk_sys) disable iff (!resetn)
        ir_update && secure && !allowed_in_secure(ir_code)
        |=> exec_pulse && exec_code == INS_BYPASS)
        else $error("disabled instruction not turned into bypass");

    AST_OPEN_PASS: assert property (@(posedge clk_sys) disable iff (!resetn)
        ir_update && !secure |=> exec_code == $past(ir_code))
        else $error("instruction altered outside secure state");

endmodule // cfgsg_ir_filter

`default_nettype wire

// *** rtl/cfgsg_gate.sv ***
`timescale 1ns/1ps
`default_nettype none

module cfgsg_gate
    import cfgsg_pkg::*;
(
    input  wire logic                clk_sys,           // 10 MHz clock
    input  wire logic                resetn,            // sync, active low
    input  wire logic [ADDR_W-1:0]   paddr,             // apb address
    input  wire logic                psel,              // apb select
    input  wire logic                penable,           // apb enable
    input  wire logic                pwrite,            // apb direction
    input  wire logic [31:0]         pwdata,            // apb write data
    output logic      [31:0]         prdata,            // apb read data
    output logic                     pready,            // apb ready
    output logic                     pslverr,           // apb error
    input  wire logic                tamper_fuse,       // fuse already blown
    output logic                     tamper_burn,       // blow tamper fuse
    input  wire logic                user_mode,         // device in user mode
    input  wire logic                config_status_n,   // status pin level
    input  wire logic [3:0]          jtag_ir,           // decoded instruction
    input  wire logic                jtag_ir_update,    // instruction loaded
    input  wire logic                key_wr_valid,      // key word strobe
    input  wire logic [2:0]          key_wr_idx,        // key word index
    input  wire logic [WORD_BITS-1:0] key_wr_data,      // key word
    output logic      [3:0]          exec_instr,        // executed instruction
    output logic                     exec_valid,        // execute strobe
    output logic                     key_check_valid,   // check answer strobe
    output logic                     key_check_cleared, // volatile key empty
    input  wire logic                img_start,         // image header seen
    input  wire logic [1:0]          img_scheme,        // scheme of image
    input  wire logic                img_encrypted,     // image encrypted
    input  wire logic                img_compressed,    // image compressed
    output logic                     img_accept,        // image accepted
    output logic                     img_reject,        // image refused
    output logic                     decrypt_en,        // decryptor on
    output logic                     decomp_en,         // decompressor on
    output logic                     decrypt_first,     // decomp fed by aes
    output logic      [2:0]          clk_ratio,         // clock per word
    output logic                     test_mode_en,      // test access allowed
    output logic      [KEY_BITS-1:0] aes_key            // key to aes core
);

    logic                locked;
    logic                tamper_set;
    logic                keysel_nv;
    logic                last_acc;
    logic                last_rej;
    logic [KEY_BITS-1:0] v_key;
    logic [KEY_BITS-1:0] nv_key;
    logic [KEY_WORDS-1:0] v_mask;
    logic [KEY_WORDS-1:0] nv_mask;

    // verdict on an image header; used by the gate and its checks
    function automatic logic image_ok(input logic [1:0] sch,
                                      input logic enc, input logic tamp,
                                      input logic key);
        if (sch == SCH_JTAG)
            return !enc && !tamp;
        else if (enc)
            return key;
        else
            return !tamp;
    endfunction

    // security state, decoded
    wire tamper_eff  = tamper_fuse | tamper_set;
    wire jtag_secure = tamper_eff & locked;
    wire v_present   = &v_mask;
    wire nv_present  = &nv_mask;
    wire key_present = keysel_nv ? nv_present : v_present;
    wire verdict     = image_ok(img_scheme, img_encrypted, tamper_eff,
                                key_present);

    // instruction decode
    wire is_lock   = exec_valid && exec_instr == INS_LOCK;
    wire is_unlock = exec_valid && exec_instr == INS_UNLOCK;
    wire is_clear  = exec_valid && exec_instr == INS_CLEAR_VOL_KEY;
    wire is_check  = exec_valid && exec_instr == INS_KEY_CHECK;

    // key writes wait for the status pin and stop once tamper is set
    wire       key_wr_ok = key_wr_valid && config_status_n &&
                           !tamper_eff;
    wire       v_wr      = key_wr_ok && !keysel_nv;
    wire       nv_wr     = key_wr_ok && keysel_nv && !nv_mask[key_wr_idx];
    wire [7:0] key_base  = {key_wr_idx, 5'h00};

    // apb decode; neither key is mapped, so it cannot be read back
    wire apb_setup = psel && !penable;
    wire apb_wr    = psel && penable && pwrite;
    wire hit_ctrl  = paddr == CTRL_OFS;
    wire hit_stat  = paddr == STAT_OFS;
    wire [31:0] ctrl_word = {30'h0, keysel_nv, tamper_eff};
    wire [31:0] stat_word = {24'h0, keysel_nv, user_mode, last_rej,
                             last_acc, nv_present, v_present,
                             tamper_eff, jtag_secure};

    assign pready      = 1'b1;
    assign pslverr     = psel && penable && !(hit_ctrl || hit_stat);
    assign tamper_burn = tamper_set;

    cfgsg_ir_filter u_filter (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .ir_code    (jtag_ir),
        .ir_update  (jtag_ir_update),
        .secure     (jtag_secure),
        .exec_code  (exec_instr),
        .exec_pulse (exec_valid)
    );

    // lock starts set, so a blown fuse means secure straight out of reset
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            locked <= 1'b1;
        else if (user_mode && is_unlock)
            locked <= 1'b0;
        else if (user_mode && is_lock)
            locked <= 1'b1;
    end

    // control register; tamper only ever sets, there is no clear path
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            tamper_set <= 1'b0;
            keysel_nv  <= KEYSEL_RESET;
        end
        else if (apb_wr && hit_ctrl)
        begin
            if (pwdata[CTRL_TAMPER_BIT])
                tamper_set <= 1'b1;
            if (!tamper_eff)
                keysel_nv <= pwdata[CTRL_KEYSEL_BIT];
        end
    end

    // read data is captured in the setup cycle for a zero-wait answer
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            prdata <= 32'h0000_0000;
        else if (apb_setup)
            prdata <= hit_ctrl ? ctrl_word :
                      hit_stat ? stat_word : 32'h0000_0000;
    end

    // volatile key: rewritable, all eight words erased together in one cycle on clear
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            v_key  <= '0;
            v_mask <= '0;
        end
        else if (is_clear)
        begin
            v_key  <= '0;
            v_mask <= '0;
        end
        else if (v_wr)
        begin
            v_key[key_base +: WORD_BITS] <= key_wr_data;
            v_mask[key_wr_idx]           <= 1'b1;
        end
    end

    // non-volatile key: each word may be written once only
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            nv_key  <= '0;
            nv_mask <= '0;
        end
        else if (nv_wr)
        begin
            nv_key[key_base +: WORD_BITS] <= key_wr_data;
            nv_mask[key_wr_idx]           <= 1'b1;
        end
    end

    // key-check answer, the key fed to the decryptor and the test-mode enable
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            key_check_valid   <= 1'b0;
            key_check_cleared <= 1'b0;
            aes_key           <= '0;
            test_mode_en      <= 1'b0;
        end
        else
        begin
            key_check_valid   <= is_check;
            key_check_cleared <= v_mask == '0;
            aes_key           <= keysel_nv ? nv_key : v_key;
            test_mode_en      <= !tamper_eff;
        end
    end

    // image gate: one-cycle accept/reject pulse, status verdict held until the next header
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            img_accept    <= 1'b0;
            img_reject    <= 1'b0;
            last_acc      <= 1'b0;
            last_rej      <= 1'b0;
            decrypt_en    <= 1'b0;
            decomp_en     <= 1'b0;
            decrypt_first <= 1'b0;
            clk_ratio     <= RATIO_PLAIN;
        end
        else
        begin
            img_accept <= img_start && verdict;
            img_reject <= img_start && !verdict;
            if (img_start)
            begin
                last_acc      <= verdict;
                last_rej      <= !verdict;
                decrypt_en    <= verdict && img_encrypted;
                decomp_en     <= verdict && img_compressed;
                decrypt_first <= verdict && img_encrypted &&
                                 img_compressed;
                clk_ratio     <= (img_scheme == SCH_FAST_PARALLEL &&
                                  (img_encrypted || img_compressed)) ?
                                 RATIO_FAST : RATIO_PLAIN;
            end
        end
    end

    sequence s_clear;
        is_clear;
    endsequence

    // the answer strobe one cycle after a key-check executes
    sequence s_check_answer;
        ##1 key_check_valid;
    endsequence

    AST_BOOT_SECURE: assert property (@(posedge clk_sys)
        $rose(resetn) && tamper_fuse |-> jtag_secure)
        else $error("tamper fuse set but not secure after reset");

    AST_UNLOCK: assert property (@(posedge clk_sys) disable iff (!resetn)
        is_unlock && user_mode |=> !jtag_secure)
        else $error("unlock in user mode left secure state on");

    AST_LOCK: assert property (@(posedge clk_sys) disable iff (!resetn)
        is_lock && user_mode && tamper_eff |=> jtag_secure)
        else $error("lock did not restore secure state");

    AST_LOCK_USER: assert property (@(posedge clk_sys) disable iff (!resetn)
        (is_lock || is_unlock) && !user_mode |=> $stable(locked))
        else $error("lock state changed outside user mode");

    AST_PLAIN_TAMPER: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        img_start && tamper_eff && !img_encrypted
        |=> img_reject && !img_accept)
        else $error("plain image accepted with tamper set");

    AST_KEY_BLOCK: assert property (@(posedge clk_sys) disable iff (!resetn)
        key_wr_valid && tamper_eff && !is_clear
        |=> $stable(v_key) && $stable(nv_key))
        else $error("key written while tamper set");

    AST_TAMPER_STICKY: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        tamper_set |=> tamper_set && !test_mode_en)
        else $error("tamper cleared or test mode back");

    AST_PLAIN_KEYED: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        img_start && !tamper_eff && key_present && img_scheme != SCH_JTAG
        |=> img_accept)
        else $error("image refused with key and no tamper");

    AST_VOL_ERASED: assert property (@(posedge clk_sys) disable iff (!resetn)
        img_start && tamper_eff && !keysel_nv && !v_present
        |=> img_reject)
        else $error("image accepted with erased volatile key");

    AST_CLEAR_CHECK: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        s_clear |=> v_mask == '0)
        else $error("volatile key not erased by clear");

    AST_CHECK_ANSWER: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        is_check |-> s_check_answer)
        else $error("key check gave no answer strobe");

    AST_JTAG_ENC: assert property (@(posedge clk_sys) disable iff (!resetn)
        img_start && img_scheme == SCH_JTAG && img_encrypted
        |=> img_reject ##1 !decrypt_en)
        else $error("encrypted jtag image accepted");

    AST_ORDER: assert property (@(posedge clk_sys) disable iff (!resetn)
        img_start && img_encrypted && img_compressed && verdict
        |=> decrypt_first && decrypt_en && decomp_en)
        else $error("decrypt-then-decompress chain not set");

endmodule // cfgsg_gate

`default_nettype wire

// *** dv/cfgsg_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// jtag host and image source on the far side of the gate
module cfgsg_host_model
    import cfgsg_pkg::*;
(
    input  wire logic        clk_sys,           // system clock
    input  wire logic        config_status_n,   // status pin level
    input  wire logic [3:0]  exec_instr,        // executed instruction
    input  wire logic        exec_valid,        // execute strobe
    input  wire logic        key_check_valid,   // check answer strobe
    input  wire logic        key_check_cleared, // volatile key empty
    input  wire logic        img_accept,        // image accepted
    input  wire logic        img_reject,        // image refused
    output logic      [3:0]  jtag_ir,           // instruction code
    output logic             jtag_ir_update,    // instruction loaded
    output logic             key_wr_valid,      // key word strobe
    output logic      [2:0]  key_wr_idx,        // key word index
    output logic      [31:0] key_wr_data,       // key word
    output logic             img_start,         // image header seen
    output logic      [1:0]  img_scheme,        // scheme of image
    output logic             img_encrypted,     // image encrypted
    output logic             img_compressed     // image compressed
);
    int i;

    // idle levels from time zero
    initial
    begin
        jtag_ir        = INS_BYPASS;
        jtag_ir_update = 1'b0;
        key_wr_valid   = 1'b0;
        key_wr_idx     = 3'h0;
        key_wr_data    = 32'h0;
        img_start      = 1'b0;
        img_scheme     = SCH_PASSIVE;
        img_encrypted  = 1'b0;
        img_compressed = 1'b0;
    end

    // one instruction; x comes back if no execute strobe shows
    task automatic run_instr(input logic [3:0] code, output logic [3:0] seen);
        @(posedge clk_sys);
        jtag_ir        <= code;
        jtag_ir_update <= 1'b1;
        @(posedge clk_sys);
        jtag_ir_update <= 1'b0;
        for (i = 0; i < 4 && exec_valid !== 1'b1; i++)
            @(posedge clk_sys);
        seen = (exec_valid === 1'b1) ? exec_instr : 4'hX;
    endtask

    // key check instruction, then its answer strobe
    task automatic check_key(output logic cleared);
        logic [3:0] s;
        run_instr(INS_KEY_CHECK, s);
        for (i = 0; i < 4 && key_check_valid !== 1'b1; i++)
            @(posedge clk_sys);
        cleared = (key_check_valid === 1'b1) ? key_check_cleared : 1'bX;
    endtask

    // eight words lowest first, once the status pin is released or after 400 cycles at most
    task automatic load_key(input logic [255:0] k);
        for (i = 0; i < 400 && config_status_n !== 1'b1; i++)
            @(posedge clk_sys);
        for (i = 0; i < 8; i++)
        begin
            @(posedge clk_sys);
            key_wr_valid <= 1'b1;
            key_wr_idx   <= 3'(i);
            key_wr_data  <= k[32*i +: 32];
        end
        @(posedge clk_sys);
        key_wr_valid <= 1'b0;
        // stale data must not look valid after the strobe drops
        key_wr_data  <= ~key_wr_data;
    endtask

    // image header, then wait for the verdict pulse
    task automatic send_img(input logic [1:0] sch, input logic enc, comp,
                            output logic acc, rej);
        @(posedge clk_sys);
        img_start      <= 1'b1;
        img_scheme     <= sch;
        img_encrypted  <= enc;
        img_compressed <= comp;
        @(posedge clk_sys);
        img_start <= 1'b0;
        for (i = 0; i < 4 && (img_accept | img_reject) !== 1'b1; i++)
            @(posedge clk_sys);
        acc = img_accept;
        rej = img_reject;
    endtask
endmodule // cfgsg_host_model

`default_nettype wire

// *** dv/cfgsg_gate_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module cfgsg_gate_tb
    import cfgsg_pkg::*;
;
    logic clk_sys, resetn, psel, penable, pwrite, tamper_fuse, user_mode;
    logic config_status_n, pready, pslverr, err, tamper_burn;
    logic [ADDR_W-1:0]   paddr;
    logic [31:0]         pwdata, prdata, rd, key_wr_data;
    logic [3:0]          jtag_ir, exec_instr, got;
    logic [2:0]          key_wr_idx, clk_ratio;
    logic [1:0]          img_scheme;
    logic jtag_ir_update, key_wr_valid, exec_valid, key_check_valid;
    logic key_check_cleared, img_start, img_encrypted, img_compressed;
    logic img_accept, img_reject, acc, rej, cl, test_mode_en;
    logic decrypt_en, decomp_en, decrypt_first;
    logic [KEY_BITS-1:0] aes_key, k1;
    int n_mismatch, total_checks, i, c, w;

    cfgsg_gate i_cfgsg_gate (
        .clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tamper_fuse(tamper_fuse), .tamper_burn(tamper_burn),
        .user_mode(user_mode), .config_status_n(config_status_n),
        .jtag_ir(jtag_ir), .jtag_ir_update(jtag_ir_update),
        .key_wr_valid(key_wr_valid), .key_wr_idx(key_wr_idx),
        .key_wr_data(key_wr_data), .exec_instr(exec_instr),
        .exec_valid(exec_valid), .key_check_valid(key_check_valid),
        .key_check_cleared(key_check_cleared), .img_start(img_start),
        .img_scheme(img_scheme), .img_encrypted(img_encrypted),
        .img_compressed(img_compressed), .img_accept(img_accept),
        .img_reject(img_reject), .decrypt_en(decrypt_en),
        .decomp_en(decomp_en), .decrypt_first(decrypt_first),
        .clk_ratio(clk_ratio), .test_mode_en(test_mode_en),
        .aes_key(aes_key));

    cfgsg_host_model i_cfgsg_host_model (
        .clk_sys(clk_sys), .config_status_n(config_status_n),
        .exec_instr(exec_instr), .exec_valid(exec_valid),
        .key_check_valid(key_check_valid),
        .key_check_cleared(key_check_cleared), .img_accept(img_accept),
        .img_reject(img_reject), .jtag_ir(jtag_ir),
        .jtag_ir_update(jtag_ir_update), .key_wr_valid(key_wr_valid),
        .key_wr_idx(key_wr_idx), .key_wr_data(key_wr_data),
        .img_start(img_start), .img_scheme(img_scheme),
        .img_encrypted(img_encrypted), .img_compressed(img_compressed));

    // 100 ns system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic chk_bit(input string nm, input logic e, g);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_word(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // apb transfer: request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 8; i++)
        begin
            @(posedge clk_sys);
            if (pready === 1'b1)
                break;
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic st(input int b, input logic e);
        apb(1'b0, STAT_OFS, 32'h0);
        chk_bit("status", e, rd[b]);
    endtask

    task automatic ins(input logic [3:0] cd, e);
        i_cfgsg_host_model.run_instr(cd, got);
        chk_word("exec_instr", {28'h0, e}, {28'h0, got});
    endtask

    task automatic img(input logic [1:0] s, input logic en, cm, e);
        i_cfgsg_host_model.send_img(s, en, cm, acc, rej);
        chk_bit("img_accept", e, acc);
        chk_bit("img_reject", !e, rej);
    endtask

    task automatic kchk(input logic e);
        i_cfgsg_host_model.check_key(cl);
        chk_bit("key_check_cleared", e, cl);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // hang guard, far beyond the few hundred cycles of the tests
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        final_report();
    end

    // main sequence
    initial
    begin
        {resetn, psel, penable, pwrite, tamper_fuse} = 5'h0;
        {paddr, pwdata, config_status_n, user_mode} = {12'h0, 32'h0, 2'h1};
        config_status_n = 1'b0;
        for (w = 0; w < 8; w++)
            k1[32*w +: 32] = {8{4'(w)}} ^ 32'h5A3C96E1;
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        st(ST_SECURE_BIT, 1'b0);
        chk_bit("test_mode_en", 1'b1, test_mode_en);
        apb(1'b0, 12'h008, 32'h0);
        chk_bit("pslverr", 1'b1, err);
        chk_word("unmapped", 32'h0, rd);
        img(SCH_PASSIVE, 1'b0, 1'b0, 1'b1);
        img(SCH_PASSIVE, 1'b1, 1'b0, 1'b0);
        config_status_n <= 1'b1;
        i_cfgsg_host_model.load_key(k1);
        // last word landed on the final edge of load_key, the key output lands one edge later
        repeat (2) @(posedge clk_sys);
        for (w = 0; w < 8; w++)
            chk_word("aes_key", k1[32*w +: 32], aes_key[32*w +: 32]);
        st(ST_VKEY_BIT, 1'b1);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk_word("ctrl", 32'h0, rd);
        img(SCH_PASSIVE, 1'b0, 1'b0, 1'b1);
        img(SCH_ACTIVE, 1'b1, 1'b1, 1'b1);
        chk_bit("decrypt_first", 1'b1, decrypt_first);
        chk_bit("decomp_en", 1'b1, decomp_en & decrypt_en);
        chk_word("clk_ratio", 32'(RATIO_PLAIN), 32'(clk_ratio));
        img(SCH_FAST_PARALLEL, 1'b1, 1'b0, 1'b1);
        chk_word("clk_ratio", 32'(RATIO_FAST), 32'(clk_ratio));
        img(SCH_JTAG, 1'b1, 1'b0, 1'b0);
        ins(INS_USERCODE, INS_USERCODE);
        ins(INS_CLEAR_VOL_KEY, INS_CLEAR_VOL_KEY);
        kchk(1'b1);
        img(SCH_PASSIVE, 1'b1, 1'b0, 1'b0);
        i_cfgsg_host_model.load_key(k1);
        kchk(1'b0);
        apb(1'b1, CTRL_OFS, 32'h1);
        repeat (2) @(posedge clk_sys);
        chk_bit("tamper_burn", 1'b1, tamper_burn);
        chk_bit("test_mode_en", 1'b0, test_mode_en);
        apb(1'b1, CTRL_OFS, 32'h0);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk_word("ctrl", 32'h1, rd);
        st(ST_SECURE_BIT, 1'b1);
        img(SCH_PASSIVE, 1'b0, 1'b0, 1'b0);
        img(SCH_PASSIVE, 1'b1, 1'b0, 1'b1);
        img(SCH_JTAG, 1'b0, 1'b0, 1'b0);
        i_cfgsg_host_model.load_key(~k1);
        chk_word("aes_key", k1[31:0], aes_key[31:0]);
        // every code but lock and unlock while secure
        for (c = 0; c < 16; c++)
            if (c != 9 && c != 10)
                ins(4'(c), (c < 4 || c == 15) ? 4'(c) : 4'hF);
        kchk(1'bX);
        @(posedge clk_sys);
        user_mode <= 1'b0;
        ins(INS_UNLOCK, INS_UNLOCK);
        st(ST_SECURE_BIT, 1'b1);
        @(posedge clk_sys);
        user_mode <= 1'b1;
        ins(INS_UNLOCK, INS_UNLOCK);
        st(ST_SECURE_BIT, 1'b0);
        for (c = 4; c < 9; c++)
            ins(4'(c), 4'(c));
        ins(INS_CLEAR_VOL_KEY, INS_CLEAR_VOL_KEY);
        kchk(1'b1);
        img(SCH_PASSIVE, 1'b1, 1'b0, 1'b0);
        ins(INS_LOCK, INS_LOCK);
        st(ST_SECURE_BIT, 1'b1);
        ins(INS_HIGHZ, INS_BYPASS);
        // second reset with the fuse already blown
        @(posedge clk_sys);
        resetn      <= 1'b0;
        tamper_fuse <= 1'b1;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        st(ST_SECURE_BIT, 1'b1);
        st(ST_TAMPER_BIT, 1'b1);
        chk_bit("test_mode_en", 1'b0, test_mode_en);
        ins(INS_CLAMP, INS_BYPASS);
        final_report();
    end
endmodule // cfgsg_gate_tb

`default_nettype wire
